//--- include/toc_defs.vh
// Purpose: constants for the traction option control block
// Assumes: 10 MHz clock, APB register access
// Notes: percentages are 0..100, times in 0.1 s units
`ifndef TOC_DEFS_VH
`define TOC_DEFS_VH

`define TOC_CLK_HZ 10000000
`define TOC_TENTH_CYC (`TOC_CLK_HZ / 10)
`define TOC_HOUR_TENTHS 36000
`define TOC_SEAT_DEBOUNCE_MS 200
`define TOC_SEAT_DEBOUNCE_CYC ((`TOC_CLK_HZ / 1000) * `TOC_SEAT_DEBOUNCE_MS)

// register byte addresses
`define TOC_REG_OPTIONS 12'h000
`define TOC_REG_THROTTLE 12'h004
`define TOC_REG_RAMPS_A 12'h008
`define TOC_REG_RAMPS_B 12'h00c
`define TOC_REG_CHECKUP 12'h010
`define TOC_REG_STATUS 12'h014
`define TOC_REG_HOURS 12'h018
`define TOC_REG_SPEED 12'h01c

// options register fields
`define TOC_OPT_SEAT 0
`define TOC_OPT_HOUR_KEYON 1
`define TOC_OPT_BATT_LO 2
`define TOC_OPT_BATT_HI 3
`define TOC_OPT_RAMP_HOLD 4
`define TOC_OPT_AUX_LO 5
`define TOC_OPT_AUX_HI 6
`define TOC_OPT_QINV_LO 7
`define TOC_OPT_QINV_HI 8
`define TOC_OPT_TEMP_LO 9
`define TOC_OPT_TEMP_HI 10
`define TOC_OPT_INV_NC 11
`define TOC_OPT_AUXTIME_LO 16
`define TOC_OPT_AUXTIME_HI 22
`define TOC_OPT_RESET 32'h0000_0000

// mode encodings
`define TOC_AUX_BRAKE 2'h0
`define TOC_AUX_STEER_MOTION 2'h1
`define TOC_AUX_STEER_EXCL 2'h2
`define TOC_QINV_NONE 2'h0
`define TOC_QINV_TIMED 2'h1
`define TOC_TEMP_ANALOG 2'h0
`define TOC_TEMP_DIGITAL 2'h1

// levels and limits
`define TOC_BATT_LOW_PCT 7'h0a
`define TOC_BATT_SPEED_PCT 7'h18
`define TOC_FULL_PCT 7'h64
`define TOC_CHECK_WARN_H 16'h012c
`define TOC_CHECK_SLOW_H 16'h0154
`define TOC_CHECK_STOP_H 16'h017c
`define TOC_CHECK_SLOW_PCT 7'h32
`define TOC_QINV_TENTHS 7'h0f
`define TOC_FREQ_FULL 16'h03e8
`define TOC_TEMP_HOT_LEVEL 10'h300
`define TOC_THROTTLE_RESET 32'h0000_3246
`define TOC_RAMP_RESET 32'h0a0a_0a0a

`endif

//--- core/toc_tick_timer.v
// Purpose: counts one pulse per period of a fixed number of cycles
// Assumes: run high keeps counting, low clears
// Notes: used for the tenth-second base
`timescale 1ns/10ps
module toc_tick_timer #(
    parameter PERIOD = 1000000,
    parameter W = 20
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // control
    input wire run,
    output reg tick
);
    reg [W-1:0] count;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= {W{1'b0}};
            tick <= 1'b0;
        end else if (!run) begin
            count <= {W{1'b0}};
            tick <= 1'b0;
        end else if (count == PERIOD[W-1:0] - 1'b1) begin
            count <= {W{1'b0}};
            tick <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

//--- core/toc_ramp.v
// Purpose: linear frequency ramp toward a target
// Assumes: full scale 1000 units = 100 Hz; times in 0.1 s
// Notes: step per tenth-second is full scale over the time
`timescale 1ns/10ps
`include "toc_defs.vh"
module toc_ramp (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // control
    input wire tick,
    input wire [15:0] target,
    input wire [6:0] up_time,
    input wire [6:0] down_time,
    output reg [15:0] freq
);
    reg [15:0] step_up;
    reg [15:0] step_dn;

    always @* begin
        step_up = (up_time == 7'h00) ? `TOC_FREQ_FULL : (`TOC_FREQ_FULL / {9'h000, up_time});
        step_dn = (down_time == 7'h00) ? `TOC_FREQ_FULL :
                  (`TOC_FREQ_FULL / {9'h000, down_time});
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freq <= 16'h0000;
        end else if (freq < target) begin
            if (up_time == 7'h00)
                freq <= target;
            else if (tick)
                freq <= (target - freq <= step_up) ? target : freq + step_up;
        end else if (freq > target) begin
            if (down_time == 7'h00)
                freq <= target;
            else if (tick)
                freq <= (freq - target <= step_dn) ? target : freq - step_dn;
        end
    end
endmodule

//--- core/toc_traction_ctrl.v
// Purpose: option-driven traction control of a truck inverter
// Assumes: inputs synchronous to clk; console writes via APB
// Notes: frequency in 0.1 Hz units; speed percentages 0..100
// Behaviour
// - handle mode: tiller release acts at once
// - seat mode: release recognised after debounce
// - hours count running or key-on per option
// - battery level 0: compute, take no action
// - levels 1,3: alarm at 10%, inhibit lift
// - level 2: also limit speed to 24%
// - ramp hold keeps truck for auxiliary time
// - hold off: slow descent during auxiliary time
// - after auxiliary time: brake, release bridge
// - aux output: brake or motion steering contactor
// - exclusive steering contactor or unused output
// - quick inversion none, timed or belly
// - inversion polarity selects closed or open active
// - motor sensor analog, digital or ignored
// - pedal deadband before any speed demand
// - two-segment pedal curve through knee point
// - check-up warning from 300 hours if enabled
// - option 2 slows at 340, 3 stops 380
// - acceleration ramp time for 0 to 100 Hz
// - release or tiller braking deceleration time
// - reversal, backoff, limit and curve decel times
// - auxiliary time 0 to 12.7 s, 0.1 s
`timescale 1ns/10ps
`include "toc_defs.vh"
module toc_traction_ctrl #(
    parameter SEAT_DEBOUNCE_CYC = `TOC_SEAT_DEBOUNCE_CYC,
    parameter TENTH_CYC = `TOC_TENTH_CYC
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // operator inputs
    input wire key_on,
    input wire presence_in,
    input wire dir_fwd,
    input wire dir_rev,
    input wire brake_pedal,
    input wire steer_excl_in,
    input wire qinv_in,
    input wire curve_cutback,
    input wire speed_reduce,
    input wire encoder_present,
    input wire [6:0] pedal_pct,
    input wire [6:0] battery_pct,
    input wire [9:0] motor_temp_analog,
    input wire motor_temp_digital,
    // outputs
    output reg aux_out,
    output reg bridge_enable,
    output reg hold_active,
    output reg lift_inhibit,
    output reg battery_low_alarm,
    output reg checkup_warning,
    output reg truck_stopped,
    output reg qinv_active,
    output reg motor_overtemp,
    output wire [15:0] motor_freq
);
    // states of the stop-on-ramp sequencer
    localparam ST_RUN = 3'b001;
    localparam ST_HOLD = 3'b010;
    localparam ST_PARK = 3'b100;

    reg [31:0] opt, thr, ramps_a, ramps_b, rdata, rdata_q, deb_cnt, scaled;
    reg [15:0] hours, hour_tenths, target, span, prod;
    reg [6:0] aux_cnt, qinv_cnt, prev_limit, speed_cap, curve_pct, next_cap, down_time;
    reg [2:0] state, dec_sel;
    reg [1:0] check_type;
    reg check_done, presence, prev_fwd, prev_rev;
    wire tick, travel_req, qinv_raw, wr, batt_low;
    wire [1:0] aux_mode, batt_mode, qinv_mode, temp_mode;
    wire [6:0] aux_time, deadband, knee_x, knee_y;

    assign aux_mode = opt[`TOC_OPT_AUX_HI:`TOC_OPT_AUX_LO];
    assign batt_mode = opt[`TOC_OPT_BATT_HI:`TOC_OPT_BATT_LO];
    assign qinv_mode = opt[`TOC_OPT_QINV_HI:`TOC_OPT_QINV_LO];
    assign temp_mode = opt[`TOC_OPT_TEMP_HI:`TOC_OPT_TEMP_LO];
    assign aux_time = opt[`TOC_OPT_AUXTIME_HI:`TOC_OPT_AUXTIME_LO];
    assign deadband = thr[6:0];
    assign knee_x = thr[14:8];
    assign knee_y = thr[22:16];
    assign travel_req = presence && (dir_fwd ^ dir_rev);
    assign qinv_raw = opt[`TOC_OPT_INV_NC] ? !qinv_in : qinv_in;
    assign batt_low = battery_pct <= `TOC_BATT_LOW_PCT;

    // apb: zero wait states, unmapped reads zero without error
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = rdata_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            rdata_q <= 32'h0000_0000;
        else if (psel && !penable)
            rdata_q <= rdata;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt <= `TOC_OPT_RESET;
            thr <= `TOC_THROTTLE_RESET;
            ramps_a <= `TOC_RAMP_RESET;
            ramps_b <= `TOC_RAMP_RESET;
            check_type <= 2'h0;
        end else if (wr) begin
            case (paddr)
                `TOC_REG_OPTIONS: opt <= pwdata;
                `TOC_REG_THROTTLE: thr <= pwdata;
                `TOC_REG_RAMPS_A: ramps_a <= pwdata;
                `TOC_REG_RAMPS_B: ramps_b <= pwdata;
                `TOC_REG_CHECKUP: check_type <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    always @* begin
        case (paddr)
            `TOC_REG_OPTIONS: rdata = opt;
            `TOC_REG_THROTTLE: rdata = thr;
            `TOC_REG_RAMPS_A: rdata = ramps_a;
            `TOC_REG_RAMPS_B: rdata = ramps_b;
            `TOC_REG_CHECKUP: rdata = {29'h0, check_done, check_type};
            `TOC_REG_STATUS: rdata = {22'h0, motor_overtemp, qinv_active, truck_stopped,
                                      checkup_warning, battery_low_alarm, lift_inhibit,
                                      hold_active, bridge_enable, aux_out, presence};
            `TOC_REG_HOURS: rdata = {16'h0, hours};
            `TOC_REG_SPEED: rdata = {9'h0, speed_cap, motor_freq};
            default: rdata = 32'h0000_0000;
        endcase
    end

    toc_tick_timer #(
        .PERIOD(TENTH_CYC),
        .W(24)
    ) u_tenth (
        .clk(clk),
        .rst_n(rst_n),
        .run(1'b1),
        .tick(tick)
    );

    // operator presence with optional seat debounce
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presence <= 1'b0;
            deb_cnt <= 32'h0;
        end else if (presence_in) begin
            presence <= 1'b1;
            deb_cnt <= 32'h0;
        end else if (!opt[`TOC_OPT_SEAT]) begin
            presence <= 1'b0;
        end else if (deb_cnt >= SEAT_DEBOUNCE_CYC - 1) begin
            presence <= 1'b0;
        end else begin
            deb_cnt <= deb_cnt + 32'h1;
        end
    end

    // hour meter and check-up flags
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hours <= 16'h0;
            hour_tenths <= 16'h0;
            check_done <= 1'b0;
        end else begin
            if (tick && key_on && (opt[`TOC_OPT_HOUR_KEYON] || motor_freq != 16'h0)) begin
                if (hour_tenths == `TOC_HOUR_TENTHS - 1) begin
                    hour_tenths <= 16'h0;
                    hours <= hours + 16'h1;
                end else begin
                    hour_tenths <= hour_tenths + 16'h1;
                end
            end
            if (wr && paddr == `TOC_REG_CHECKUP)
                check_done <= pwdata[2];
        end
    end

    // stop on ramp sequencer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_PARK;
            aux_cnt <= 7'h0;
        end else begin
            case (state)
                ST_RUN: begin
                    aux_cnt <= 7'h0;
                    if (!presence)
                        state <= ST_PARK;
                    else if (!travel_req && motor_freq == 16'h0)
                        state <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (travel_req) begin
                        state <= ST_RUN;
                    end else if (!presence || aux_cnt >= aux_time) begin
                        state <= ST_PARK;
                    end else if (tick) begin
                        aux_cnt <= aux_cnt + 7'h1;
                    end
                end
                ST_PARK: begin
                    if (travel_req)
                        state <= ST_RUN;
                end
                default: state <= ST_PARK;
            endcase
        end
    end

    // quick inversion timer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qinv_active <= 1'b0;
            qinv_cnt <= 7'h0;
        end else if (qinv_mode == `TOC_QINV_NONE || !qinv_raw) begin
            qinv_active <= 1'b0;
            qinv_cnt <= 7'h0;
        end else if (qinv_mode == `TOC_QINV_TIMED) begin
            qinv_active <= qinv_cnt < `TOC_QINV_TENTHS;
            if (tick && qinv_cnt < `TOC_QINV_TENTHS)
                qinv_cnt <= qinv_cnt + 7'h1;
        end else begin
            qinv_active <= 1'b1;
        end
    end

    // pedal curve and speed limits
    always @* begin
        prod = 16'h0;
        if (pedal_pct <= deadband || !travel_req) begin
            curve_pct = 7'h0;
        end else if (pedal_pct <= knee_x) begin
            span = {9'h0, knee_x - deadband};
            if (span != 16'h0)
                prod = ({9'h0, pedal_pct - deadband} * {9'h0, knee_y}) / span;
            curve_pct = prod[6:0];
        end else begin
            span = {9'h0, `TOC_FULL_PCT - knee_x};
            prod = {9'h0, knee_y};
            if (span != 16'h0)
                prod = prod + ({9'h0, pedal_pct - knee_x} *
                       {9'h0, `TOC_FULL_PCT - knee_y}) / span;
            curve_pct = prod[6:0];
        end
        if (pedal_pct <= deadband || !travel_req)
            span = 16'h0;
        next_cap = `TOC_FULL_PCT;
        if (batt_mode == 2'h2 && batt_low && next_cap > `TOC_BATT_SPEED_PCT)
            next_cap = `TOC_BATT_SPEED_PCT;
        if (check_type >= 2'h2 && !check_done && hours >= `TOC_CHECK_SLOW_H &&
            next_cap > `TOC_CHECK_SLOW_PCT)
            next_cap = `TOC_CHECK_SLOW_PCT;
        if (curve_pct > next_cap)
            curve_pct = next_cap;
        scaled = ({25'h0, curve_pct} * {16'h0, `TOC_FREQ_FULL}) / {25'h0, `TOC_FULL_PCT};
        target = (state == ST_RUN && !truck_stopped) ? scaled[15:0] : 16'h0;
        // pick deceleration time by cause
        if (!presence)
            down_time = ramps_a[22:16];
        else if (!travel_req)
            down_time = ramps_a[14:8];
        else
            case (dec_sel)
                3'b001: down_time = ramps_a[30:24];
                3'b010: down_time = ramps_b[6:0];
                3'b100: down_time = ramps_b[14:8];
                default: down_time = ramps_b[22:16];
            endcase
    end

    // remember why the demand dropped
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_fwd <= 1'b0;
            prev_rev <= 1'b0;
            prev_limit <= `TOC_FULL_PCT;
            dec_sel <= 3'b000;
            speed_cap <= `TOC_FULL_PCT;
        end else begin
            prev_fwd <= dir_fwd;
            prev_rev <= dir_rev;
            prev_limit <= next_cap;
            speed_cap <= next_cap;
            if ((prev_fwd && dir_rev) || (prev_rev && dir_fwd))
                dec_sel <= 3'b001;
            else if (speed_reduce || next_cap < prev_limit)
                dec_sel <= 3'b100;
            else if (curve_cutback)
                dec_sel <= 3'b000;
            else if (motor_freq > target)
                dec_sel <= dec_sel == 3'b000 ? 3'b010 : dec_sel;
            else
                dec_sel <= 3'b010;
        end
    end

    toc_ramp u_ramp (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .target(target),
        .up_time(ramps_a[6:0]),
        .down_time(down_time),
        .freq(motor_freq)
    );

    // registered outputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_out <= 1'b0;
            bridge_enable <= 1'b0;
            hold_active <= 1'b0;
            lift_inhibit <= 1'b0;
            battery_low_alarm <= 1'b0;
            checkup_warning <= 1'b0;
            truck_stopped <= 1'b0;
            motor_overtemp <= 1'b0;
        end else begin
            battery_low_alarm <= batt_mode != 2'h0 && batt_low;
            lift_inhibit <= batt_mode != 2'h0 && batt_low;
            checkup_warning <= check_type != 2'h0 && !check_done &&
                               hours >= `TOC_CHECK_WARN_H;
            truck_stopped <= check_type == 2'h3 && !check_done &&
                             hours >= `TOC_CHECK_STOP_H;
            hold_active <= state == ST_HOLD && opt[`TOC_OPT_RAMP_HOLD] &&
                           encoder_present;
            bridge_enable <= state == ST_RUN || (state == ST_HOLD && opt[`TOC_OPT_RAMP_HOLD] &&
                             encoder_present);
            case (temp_mode)
                `TOC_TEMP_ANALOG: motor_overtemp <= motor_temp_analog >= `TOC_TEMP_HOT_LEVEL;
                `TOC_TEMP_DIGITAL: motor_overtemp <= motor_temp_digital;
                default: motor_overtemp <= 1'b0;
            endcase
            case (aux_mode)
                `TOC_AUX_BRAKE: aux_out <= state != ST_PARK;
                `TOC_AUX_STEER_MOTION: aux_out <= dir_fwd || dir_rev || brake_pedal ||
                                                  motor_freq != 16'h0;
                `TOC_AUX_STEER_EXCL: aux_out <= steer_excl_in;
                default: aux_out <= 1'b0;
            endcase
        end
    end
endmodule

//--- dv/toc_assertions.sv
// Purpose: port checks for traction option control
// Assumes: shadows follow console writes
// Notes: outputs lag their cause by one edge
`timescale 1ns/10ps
module toc_checker (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // operator inputs
    input wire steer_excl_in,
    input wire encoder_present,
    input wire [6:0] battery_pct,
    input wire [9:0] motor_temp_analog,
    input wire motor_temp_digital,
    // outputs
    input wire aux_out,
    input wire hold_active,
    input wire lift_inhibit,
    input wire battery_low_alarm,
    input wire motor_overtemp,
    input wire [15:0] motor_freq
);
    reg [31:0] opt, ra;
    wire [1:0] lvl = opt[3:2];
    wire [1:0] tmode = opt[10:9];
    wire [1:0] amode = opt[6:5];
    wire hold_en = opt[4];
    wire [6:0] acc = ra[6:0];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt <= 32'h0;
            ra <= 32'h0a0a_0a0a;
        end else if (psel && penable && pwrite) begin
            if (paddr == 12'h000)
                opt <= pwdata;
            if (paddr == 12'h008)
                ra <= pwdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_batt_silent: assert property ($past(lvl) == 2'h0 |->
        !battery_low_alarm && !lift_inhibit)
        else $error("alarm at battery level 0");
    chk_batt_alarm: assert property ($past(lvl) != 2'h0 |->
        battery_low_alarm == ($past(battery_pct) <= 7'h0a))
        else $error("low battery alarm wrong");
    chk_lift_follow: assert property (lift_inhibit == ($past(lvl) != 2'h0 &&
        $past(battery_pct) <= 7'h0a))
        else $error("lift not inhibited");
    chk_temp_select: assert property (motor_overtemp == ($past(tmode) == 2'h0 ?
        $past(motor_temp_analog) >= 10'h300 : $past(tmode) == 2'h1 && $past(motor_temp_digital)))
        else $error("motor temperature reading wrong");
    chk_aux_excl: assert property ($past(amode) == 2'h2 |->
        aux_out == $past(steer_excl_in))
        else $error("exclusive steering output wrong");
    chk_aux_free: assert property (amode == 2'h3 && $stable(amode) |=> !aux_out)
        else $error("free output driven");
    chk_hold_cause: assert property ($rose(hold_active) |->
        $past(hold_en) && $past(encoder_present))
        else $error("hold without option or encoder");
    chk_rise_step: assert property ($past(acc) != 7'h0 && motor_freq > $past(motor_freq) |->
        motor_freq - $past(motor_freq) <= 16'h03e8 / $past(acc))
        else $error("acceleration step too large");
endmodule
bind toc_traction_ctrl toc_checker toc_checker_inst (.clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .steer_excl_in, .encoder_present, .battery_pct, .motor_temp_analog,
    .motor_temp_digital, .aux_out, .hold_active, .lift_inhibit, .battery_low_alarm,
    .motor_overtemp, .motor_freq);

//--- dv/toc_console.sv
// Purpose: console side, apb master
// Assumes: one word per access
// Notes: waits on pready, no fixed count
`timescale 1ns/10ps
module toc_console (
    // clock
    input wire clk,
    // apb master
    output reg psel,
    output reg penable,
    output reg pwrite,
    output reg [11:0] paddr,
    output reg [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end
    task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1)
                @(posedge clk);
            q = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
            pwdata <= ~d;
        end
    endtask
endmodule

//--- dv/tb_top.sv
// Purpose: self-checking bench for traction option control
// Assumes: tick and debounce counts shortened to 10
// Notes: fixed seed, corner values mixed in
`timescale 1ns/10ps
`include "toc_defs.vh"
`define CMP(n, e, g) \
    begin \
        num_checks = num_checks + 1; \
        if ((g) !== (e)) begin \
            num_errors = num_errors + 1; \
            $display("MISMATCH %s exp %0h got %0h", n, e, g); \
        end \
    end
module tb_top;
    reg clk, rst_n, key_on, presence_in, dir_fwd, dir_rev, brake_pedal, steer_excl_in;
    reg qinv_in, curve_cutback, speed_reduce, encoder_present, motor_temp_digital;
    reg [6:0] pedal_pct, battery_pct;
    reg [9:0] motor_temp_analog;
    wire psel, penable, pwrite, pready, pslverr;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire aux_out, bridge_enable, hold_active, lift_inhibit, battery_low_alarm;
    wire checkup_warning, truck_stopped, qinv_active, motor_overtemp;
    wire [15:0] motor_freq, f;
    integer num_errors, num_checks, i, n, mx;
    reg [31:0] q, opt;
    reg [55:0] ped_tab = 56'h1e641e324b6405;
    reg [55:0] bat_tab = 56'h05056464646464;
    toc_traction_ctrl #(.SEAT_DEBOUNCE_CYC(10), .TENTH_CYC(10)) toc_traction_ctrl_inst (
        .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .key_on, .presence_in, .dir_fwd, .dir_rev, .brake_pedal, .steer_excl_in, .qinv_in,
        .curve_cutback, .speed_reduce, .encoder_present, .pedal_pct, .battery_pct,
        .motor_temp_analog, .motor_temp_digital, .aux_out, .bridge_enable, .hold_active,
        .lift_inhibit, .battery_low_alarm, .checkup_warning, .truck_stopped, .qinv_active,
        .motor_overtemp, .motor_freq);
    toc_console toc_console_inst (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready);
    assign f = exp_freq(ped_tab[8*i +: 7], bat_tab[8*i +: 7]);
    function exp_alarm(input [1:0] lvl, input [6:0] b);
        exp_alarm = lvl != 2'h0 && b <= `TOC_BATT_LOW_PCT;
    endfunction
    function exp_hot(input [1:0] m, input [9:0] a, input d);
        exp_hot = (m == `TOC_TEMP_ANALOG) ? a >= `TOC_TEMP_HOT_LEVEL : m == `TOC_TEMP_DIGITAL && d;
    endfunction
    // knee at 50% pedal, 20% speed, deadband 10%
    function [15:0] exp_freq(input [6:0] p, input [6:0] b);
        integer s;
        begin
            s = (p <= 10) ? 0 : (p <= 50) ? (p - 10) * 20 / 40 : 20 + (p - 50) * 80 / 50;
            if (b <= `TOC_BATT_LOW_PCT && s > `TOC_BATT_SPEED_PCT)
                s = `TOC_BATT_SPEED_PCT;
            exp_freq = s * 10;
        end
    endfunction
    task wr(input [11:0] a, input [31:0] d);
        toc_console_inst.xfer(1'b1, a, d, q);
    endtask
    task rd(input [11:0] a);
        toc_console_inst.xfer(1'b0, a, 32'h0, q);
    endtask
    task tally_and_finish;
        begin
            if (num_errors == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #3000000;
        num_errors = num_errors + 1;
        tally_and_finish;
    end
    initial begin
        {rst_n, key_on, presence_in, dir_fwd, dir_rev, brake_pedal, steer_excl_in} = 7'h0;
        {qinv_in, curve_cutback, speed_reduce, encoder_present, motor_temp_digital} = 5'h0;
        pedal_pct = 7'h0;
        battery_pct = 7'h64;
        motor_temp_analog = 10'h0;
        num_errors = 0;
        num_checks = 0;
        i = 0;
        n = $urandom(72700);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        key_on <= 1'b1;
        presence_in <= 1'b1;
        rd(`TOC_REG_THROTTLE);
        `CMP("throttle", `TOC_THROTTLE_RESET, q)
        rd(`TOC_REG_RAMPS_A);
        `CMP("ramps", `TOC_RAMP_RESET, q)
        wr(12'h020, 32'hffff_ffff);
        rd(12'h020);
        `CMP("unmapped", 32'h0, q)
        for (i = 0; i < 40; i = i + 1) begin
            opt = ($urandom & 32'h007f_09f3) | (i[1:0] << 2) | (i[3:2] << 9);
            wr(`TOC_REG_OPTIONS, opt);
            battery_pct <= (i % 3 == 0) ? 7'h0a : (i % 3 == 1) ? 7'h0b : 7'($urandom % 101);
            motor_temp_analog <= (i % 5 < 2) ? 10'h2ff + 10'(i % 2) : 10'($urandom);
            {motor_temp_digital, steer_excl_in, qinv_in, encoder_present} <= 4'($urandom);
            repeat (3) @(posedge clk);
            @(negedge clk);
            `CMP("alarm", exp_alarm(opt[3:2], battery_pct), battery_low_alarm)
            `CMP("lift", exp_alarm(opt[3:2], battery_pct), lift_inhibit)
            `CMP("hot", exp_hot(opt[10:9], motor_temp_analog, motor_temp_digital),
                motor_overtemp)
            if (opt[6:5] > 2'h1)
                `CMP("aux", opt[5] ? 1'b0 : steer_excl_in, aux_out)
            if (opt[8:7] == `TOC_QINV_NONE)
                `CMP("qinv", 1'b0, qinv_active)
            else if (opt[8] == 1'b1)
                `CMP("belly", opt[11] ? !qinv_in : qinv_in, qinv_active)
        end
        motor_temp_analog <= 10'h0;
        wr(`TOC_REG_THROTTLE, 32'h0014_320a);
        wr(`TOC_REG_RAMPS_A, 32'h0000_0005);
        wr(`TOC_REG_RAMPS_B, 32'h0);
        wr(`TOC_REG_OPTIONS, 32'h0005_0018);
        wr(`TOC_REG_CHECKUP, 32'h0000_0004);
        {dir_fwd, encoder_present} <= 2'h3;
        for (i = 0; i < 7; i = i + 1) begin
            @(posedge clk);
            pedal_pct <= ped_tab[8*i +: 7];
            battery_pct <= bat_tab[8*i +: 7];
            mx = 0;
            q = motor_freq;
            for (n = 0; n < 300 && (n == 0 || motor_freq !== f); n = n + 1) begin
                @(negedge clk);
                if (motor_freq > q[15:0] && motor_freq - q[15:0] > mx)
                    mx = motor_freq - q[15:0];
                q = motor_freq;
            end
            `CMP("freq", f, motor_freq)
            if (i == 1) begin
                `CMP("rise", `TOC_FREQ_FULL / 5, mx)
                `CMP("accel", 1, n > 39 && n < 60)
            end
        end
        @(posedge clk);
        dir_fwd <= 1'b0;
        for (n = 0; n < 300 && motor_freq !== 16'h0; n = n + 1)
            @(negedge clk);
        `CMP("stop", 16'h0, motor_freq)
        `CMP("stop_time", 1, n < 25)
        `CMP("warning", 1'b0, checkup_warning)
        repeat (3) @(negedge clk);
        `CMP("hold", 2'h3, {hold_active, bridge_enable})
        `CMP("brake_off", 1'b1, aux_out)
        repeat (60) @(negedge clk);
        `CMP("park", 3'h0, {hold_active, bridge_enable, aux_out})
        tally_and_finish;
    end
endmodule
